// [pkg/pdu_defs.svh]
// Register offsets, field positions, base address and codes of the peripheral DMA unit
`ifndef PDU_DEFS_SVH
`define PDU_DEFS_SVH
`define PDU_OFF_ADDR_NOW   6'h00
`define PDU_OFF_SRC_SEL    6'h04
`define PDU_OFF_ITEMS_LEFT 6'h08
`define PDU_OFF_ADDR_NEXT  6'h0c
`define PDU_OFF_ITEMS_NEXT 6'h10
`define PDU_OFF_COMMAND    6'h14
`define PDU_OFF_CONFIG     6'h18
`define PDU_OFF_STATE      6'h1c
`define PDU_OFF_IRQ_EN     6'h20
`define PDU_OFF_IRQ_DIS    6'h24
`define PDU_OFF_IRQ_MASK   6'h28
`define PDU_OFF_IRQ_FLAG   6'h2c
`define PDU_CMD_TURN_ON    0
`define PDU_CMD_TURN_OFF   1
`define PDU_CMD_FAULT_REL  8
`define PDU_IRQ_RELOAD0    0
`define PDU_IRQ_FINISHED   1
`define PDU_IRQ_FAULT      2
`define PDU_W_BYTE         2'h0
`define PDU_W_HALF         2'h1
`define PDU_W_WORD         2'h2
`define PDU_CODE_DIR_BIT   7
`define PDU_PER_BASE       32'hffff_0000
`define PDU_RESP_OKAY      2'h0
`define PDU_RESP_SLVERR    2'h2
`endif

// [pkg/pdu_pkg.sv]
// Types shared by the peripheral DMA unit
package pdu_pkg;
  typedef enum logic [1:0] {PDU_IDLE, PDU_FIRST, PDU_SECOND} pdu_state_t;
  // Channel configuration word, low bits
  typedef struct packed {
    logic       event_gate;
    logic       circular_mode;
    logic [1:0] transfer_width;
  } pdu_cfg_t;
  // One memory access
  typedef struct packed {
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdu_mem_req_t;
  // One peripheral holding register access
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdu_per_req_t;
endpackage

// [rtl/pdu_dma.sv]
// Multi-channel peripheral DMA unit with AXI4-Lite register slave
// Behaviour
// - Each channel keeps its own address, count, reload address and reload count.
// - Peripheral raises request; unit acknowledges when the item transfer begins.
// - While the clock run enable is low everything holds its state.
// - Channels are independent, each with its own registers and request.
// - Peripheral code selects direction, handshake line and holding register address.
// - Current address steps by one, two or four per item; always readable.
// - Item count drops by one per item, whatever the width; readable.
// - Writing non-zero count or reload count on enabled channel starts transfers.
// - Count at zero with reload non-zero copies reloads in, then clears them.
// - Reload count write while count is zero loads current registers at once.
// - Circular mode keeps the reload registers after a reload.
// - Width per channel is byte, halfword or word.
// - Memory uses width and alignment; unused upper peripheral bits read zero.
// - Turn-on and turn-off command bits set enable, shown in channel state.
// - Enabled channel serves requests while count and reload count are not both zero.
// - Enable and disable registers set and clear mask; mask and flags readable.
// - Three sources: reload zero, finished, memory access fault.
// - Lowest numbered requesting channel is granted first.
// - Memory fault flags and stops channel until fault release is written.
// - Event gate allows exactly one item per received event; a one-bit credit here merges events that come before the next grant.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`include "pdu_defs.svh"
module pdu_dma #(
  parameter int NCH  = 4,
  parameter int NPER = 8
) (
  // Clock, reset, clock run enable
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_clk_run,
  // AXI4-Lite slave
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [11:0]          i_awaddr,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  output logic [1:0]                o_bresp,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  input  wire logic [11:0]          i_araddr,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  // Peripheral handshake and events
  input  wire logic [NPER-1:0]      i_per_req,
  output logic [NPER-1:0]           o_per_ack,
  input  wire logic [NCH-1:0]       i_event,
  // Peripheral holding register access
  output logic                      o_per_valid,
  output pdu_pkg::pdu_per_req_t     o_per_req,
  input  wire logic                 i_per_ready,
  input  wire logic [31:0]          i_per_rdata,
  // Memory master access
  output logic                      o_mem_valid,
  output pdu_pkg::pdu_mem_req_t     o_mem_req,
  input  wire logic                 i_mem_ready,
  input  wire logic                 i_mem_err,
  input  wire logic [31:0]          i_mem_rdata,
  // Per-channel interrupt lines
  output logic [NCH-1:0]            o_irq
);
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int HW = (NPER > 1) ? $clog2(NPER) : 1;

  // Width mask for peripheral data
  function automatic logic [31:0] width_mask(input logic [1:0] w);
    case (w)
      `PDU_W_BYTE: width_mask = 32'h0000_00ff;
      `PDU_W_HALF: width_mask = 32'h0000_ffff;
      default:     width_mask = 32'hffff_ffff;
    endcase
  endfunction

  // Per-channel storage
  logic [31:0]       addr_now_reg   [NCH];
  logic [31:0]       addr_next_reg  [NCH];
  logic [15:0]       items_left_reg [NCH];
  logic [15:0]       items_next_reg [NCH];
  logic [7:0]        code_reg       [NCH];
  pdu_pkg::pdu_cfg_t cfg_reg        [NCH];
  logic [2:0]        mask_reg       [NCH];
  logic [2:0]        flag_w         [NCH];
  logic [NCH-1:0]    en_reg;
  logic [NCH-1:0]    fault_reg;
  logic [NCH-1:0]    evp_reg;
  logic [NCH-1:0]    elig_w;

  // Bus slave state
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // Engine state
  pdu_pkg::pdu_state_t st_reg;
  logic [CW-1:0]     gnt_reg;
  logic [31:0]       data_reg;
  logic [CW-1:0]     sel_w;
  logic              any_w;

  // Write decode: address and data taken together when no response waits
  wire        wr_go   = i_clk_run & i_awvalid & i_wvalid & ~bvalid_reg;
  wire [5:0]  wr_off  = i_awaddr[5:0];
  wire [5:0]  wr_chx  = i_awaddr[11:6];
  wire        wr_map  = (wr_chx < 6'(NCH)) & (wr_off <= `PDU_OFF_IRQ_FLAG);
  wire        wr_full = &i_wstrb;
  wire        rd_go   = i_clk_run & i_arvalid & ~rvalid_reg;
  wire [5:0]  rd_off  = i_araddr[5:0];
  wire [5:0]  rd_chx  = i_araddr[11:6];
  wire        rd_map  = (rd_chx < 6'(NCH)) & (rd_off <= `PDU_OFF_IRQ_FLAG);
  wire [CW-1:0] rd_ch = rd_chx[CW-1:0];

  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign o_arready = rd_go;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rdata   = rdata_reg;
  assign o_rresp   = rresp_reg;

  // Read data selection from the addressed channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (rd_off)
      `PDU_OFF_ADDR_NOW:   rd_val = addr_now_reg[rd_ch];
      `PDU_OFF_SRC_SEL:    rd_val = {24'h00_0000, code_reg[rd_ch]};
      `PDU_OFF_ITEMS_LEFT: rd_val = {16'h0000, items_left_reg[rd_ch]};
      `PDU_OFF_ADDR_NEXT:  rd_val = addr_next_reg[rd_ch];
      `PDU_OFF_ITEMS_NEXT: rd_val = {16'h0000, items_next_reg[rd_ch]};
      `PDU_OFF_CONFIG:     rd_val = {28'h000_0000, cfg_reg[rd_ch]};
      `PDU_OFF_STATE:      rd_val = {30'h0, fault_reg[rd_ch], en_reg[rd_ch]};
      `PDU_OFF_IRQ_MASK:   rd_val = {29'h0, mask_reg[rd_ch]};
      `PDU_OFF_IRQ_FLAG:   rd_val = {29'h0, flag_w[rd_ch]};
      default:             rd_val = 32'h0000_0000;
    endcase
  end

  // Bus responses; unmapped addresses answer SLVERR
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `PDU_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `PDU_RESP_OKAY;
    end else if (i_clk_run) begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_map ? `PDU_RESP_OKAY : `PDU_RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_map ? rd_val : 32'h0000_0000;
        rresp_reg  <= rd_map ? `PDU_RESP_OKAY : `PDU_RESP_SLVERR;
      end else if (i_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Engine side views of the granted channel
  wire [7:0]  g_code  = code_reg[gnt_reg];
  wire        g_m2p   = g_code[`PDU_CODE_DIR_BIT];
  wire [1:0]  g_width = cfg_reg[gnt_reg].transfer_width;
  wire [31:0] g_addr  = addr_now_reg[gnt_reg];
  wire [31:0] g_mask  = width_mask(g_width);
  wire [4:0]  g_shift = {g_addr[1:0], 3'b000};
  wire        mem_ph  = (st_reg == pdu_pkg::PDU_FIRST) ? g_m2p : ~g_m2p;
  wire        act     = i_clk_run & (st_reg != pdu_pkg::PDU_IDLE);
  wire        mem_hs  = act & mem_ph & i_mem_ready;
  wire        per_hs  = act & ~mem_ph & i_per_ready;
  wire        ph_end  = mem_hs | per_hs;
  wire        xfer_err  = mem_hs & i_mem_err;
  wire        xfer_done = ph_end & ~xfer_err & (st_reg == pdu_pkg::PDU_SECOND);
  wire        start     = i_clk_run & (st_reg == pdu_pkg::PDU_IDLE) & any_w;

  // Memory data: lane extraction on read, lane replication on write
  wire [31:0] mem_rd_lane = (i_mem_rdata >> g_shift) & g_mask;
  logic [31:0] mem_wr_rep;
  always_comb begin
    case (g_width)
      `PDU_W_BYTE: mem_wr_rep = {4{data_reg[7:0]}};
      `PDU_W_HALF: mem_wr_rep = {2{data_reg[15:0]}};
      default:     mem_wr_rep = data_reg;
    endcase
  end

  assign o_mem_valid       = act & mem_ph;
  assign o_mem_req.write   = ~g_m2p;
  assign o_mem_req.size    = g_width;
  assign o_mem_req.addr    = g_addr;
  assign o_mem_req.wdata   = mem_wr_rep;
  assign o_per_valid       = act & ~mem_ph;
  assign o_per_req.write   = g_m2p;
  assign o_per_req.addr    = `PDU_PER_BASE + {{(30-HW){1'b0}}, g_code[HW-1:0], 2'b00};
  assign o_per_req.wdata   = data_reg & g_mask;

  // Fixed priority: lowest requesting channel wins
  always_comb begin
    sel_w = '0;
    any_w = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (elig_w[i]) begin
        sel_w = i[CW-1:0];
        any_w = 1'b1;
      end
    end
  end

  // Transfer sequencer: one item per grant, first phase reads, second writes
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_reg   <= pdu_pkg::PDU_IDLE;
      gnt_reg  <= '0;
      data_reg <= 32'h0000_0000;
    end else if (i_clk_run) begin
      case (st_reg)
        pdu_pkg::PDU_IDLE: begin
          if (any_w) begin
            gnt_reg <= sel_w;
            st_reg  <= pdu_pkg::PDU_FIRST;
          end
        end
        pdu_pkg::PDU_FIRST: begin
          if (xfer_err) begin
            st_reg <= pdu_pkg::PDU_IDLE;
          end else if (ph_end) begin
            data_reg <= g_m2p ? mem_rd_lane : (i_per_rdata & g_mask);
            st_reg   <= pdu_pkg::PDU_SECOND;
          end
        end
        pdu_pkg::PDU_SECOND: begin
          if (ph_end) begin
            st_reg <= pdu_pkg::PDU_IDLE;
          end
        end
        default: st_reg <= pdu_pkg::PDU_IDLE;
      endcase
    end
  end

  // Acknowledge goes to the handshake line of the channel being started
  always_comb begin
    o_per_ack = '0;
    if (start) begin
      o_per_ack[code_reg[sel_w][HW-1:0]] = 1'b1;
    end
  end

  // Per-channel registers and control, one copy per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire        wr_c    = wr_go & wr_map & wr_full & (wr_chx[CW-1:0] == CW'(c));
    wire        busy_c  = (st_reg != pdu_pkg::PDU_IDLE) & (gnt_reg == CW'(c));
    wire        done_c  = xfer_done & (gnt_reg == CW'(c));
    wire        err_c   = xfer_err & (gnt_reg == CW'(c));
    wire        start_c = start & (sel_w == CW'(c));
    wire        left0   = (items_left_reg[c] == 16'h0000);
    wire        next0   = (items_next_reg[c] == 16'h0000);
    wire        reload  = left0 & ~next0 & ~busy_c;
    wire        circ    = cfg_reg[c].circular_mode;
    wire [31:0] step    = (cfg_reg[c].transfer_width == `PDU_W_BYTE) ? 32'h0000_0001 :
                          (cfg_reg[c].transfer_width == `PDU_W_HALF) ? 32'h0000_0002 :
                          32'h0000_0004;
    wire        gate_ok = ~cfg_reg[c].event_gate | evp_reg[c];

    // Eligible while enabled, not faulted, items left, an event credit held when gated, and the request line high
    assign elig_w[c] = en_reg[c] & ~fault_reg[c] & ~left0 & gate_ok &
                       i_per_req[code_reg[c][HW-1:0]];
    assign flag_w[c] = {fault_reg[c], left0 & next0, next0};
    assign o_irq[c]  = |(flag_w[c] & mask_reg[c]);

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        addr_now_reg[c]   <= 32'h0000_0000;
        addr_next_reg[c]  <= 32'h0000_0000;
        items_left_reg[c] <= 16'h0000;
        items_next_reg[c] <= 16'h0000;
        code_reg[c]       <= 8'h00;
        cfg_reg[c]        <= '0;
        mask_reg[c]       <= 3'h0;
        en_reg[c]         <= 1'b0;
        fault_reg[c]      <= 1'b0;
        evp_reg[c]        <= 1'b0;
      end else if (i_clk_run) begin
        // Event credit: a new event wins over the item that consumes the old one
        if (start_c) evp_reg[c] <= 1'b0;
        if (i_event[c]) evp_reg[c] <= 1'b1;
        if (wr_c) begin
          case (wr_off)
            `PDU_OFF_ADDR_NOW:   addr_now_reg[c] <= i_wdata;
            `PDU_OFF_SRC_SEL:    code_reg[c] <= i_wdata[7:0];
            `PDU_OFF_ITEMS_LEFT: items_left_reg[c] <= i_wdata[15:0];
            `PDU_OFF_ADDR_NEXT:  addr_next_reg[c] <= i_wdata;
            `PDU_OFF_ITEMS_NEXT: begin
              items_next_reg[c] <= i_wdata[15:0];
              if (left0) begin
                items_left_reg[c] <= i_wdata[15:0];
                addr_now_reg[c]   <= addr_next_reg[c];
                if (!circ) begin
                  items_next_reg[c] <= 16'h0000;
                  addr_next_reg[c]  <= 32'h0000_0000;
                end
              end
            end
            `PDU_OFF_COMMAND: begin
              if (i_wdata[`PDU_CMD_TURN_ON]) en_reg[c] <= 1'b1;
              if (i_wdata[`PDU_CMD_TURN_OFF]) en_reg[c] <= 1'b0;
              if (i_wdata[`PDU_CMD_FAULT_REL]) fault_reg[c] <= 1'b0;
            end
            `PDU_OFF_CONFIG:     cfg_reg[c] <= i_wdata[3:0];
            `PDU_OFF_IRQ_EN:     mask_reg[c] <= mask_reg[c] | i_wdata[2:0];
            `PDU_OFF_IRQ_DIS:    mask_reg[c] <= mask_reg[c] & ~i_wdata[2:0];
            default:             ;
          endcase
        end else if (reload) begin
          addr_now_reg[c]   <= addr_next_reg[c];
          items_left_reg[c] <= items_next_reg[c];
          if (!circ) begin
            addr_next_reg[c]  <= 32'h0000_0000;
            items_next_reg[c] <= 16'h0000;
          end
        end
        // Engine progress overrides a same-cycle software write of the pointer
        if (done_c) begin
          addr_now_reg[c]   <= addr_now_reg[c] + step;
          items_left_reg[c] <= items_left_reg[c] - 16'h0001;
        end
        if (err_c) fault_reg[c] <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_grant_gated;
    start && cfg_reg[sel_w].event_gate;
  endsequence
  sequence s_item_c0;
    xfer_done && gnt_reg == '0 && !(wr_go && wr_chx == 6'h00);
  endsequence

  ack_onehot_a: assert property ($onehot0(o_per_ack))
    else $error("more than one acknowledge");
  ack_start_a: assert property (start |-> o_per_ack != '0 ##1 st_reg == pdu_pkg::PDU_FIRST)
    else $error("start without acknowledge or sequencer step");
  grant_prio_a: assert property (start |-> (elig_w & ((NCH'(1) << sel_w) - NCH'(1))) == '0)
    else $error("lower channel was passed over");
  halt_hold_a: assert property (!i_clk_run |=> st_reg == $past(st_reg) && !o_mem_valid || i_clk_run)
    else $error("sequencer moved while halted");
  addr_step_a: assert property (s_item_c0 |=> addr_now_reg[0] == $past(addr_now_reg[0]) +
    ((cfg_reg[0].transfer_width == `PDU_W_BYTE) ? 32'h1 :
     (cfg_reg[0].transfer_width == `PDU_W_HALF) ? 32'h2 : 32'h4))
    else $error("address step wrong");
  count_dec_a: assert property (s_item_c0 |=> items_left_reg[0] == $past(items_left_reg[0]) - 16'h1)
    else $error("item count did not drop by one");
  fault_stop_a: assert property (fault_reg[0] |-> !elig_w[0])
    else $error("faulted channel still eligible");
  reload_copy_a: assert property (items_left_reg[0] == 16'h0 && items_next_reg[0] != 16'h0 &&
    st_reg == pdu_pkg::PDU_IDLE && i_clk_run && !wr_go |=>
    items_left_reg[0] == $past(items_next_reg[0]))
    else $error("reload did not copy count");
  per_mask_a: assert property (o_per_valid && o_per_req.write &&
    g_width inside {`PDU_W_BYTE, `PDU_W_HALF} |-> o_per_req.wdata[31:16] == 16'h0 &&
    (g_width != `PDU_W_BYTE || o_per_req.wdata[15:8] == 8'h0))
    else $error("upper peripheral bits not zero");
  gate_one_a: assert property (s_grant_gated |-> evp_reg[sel_w])
    else $error("gated channel started without an event");
endmodule

// [dv/pdu_far_model.sv]
// Far-side model: peripheral request lines, holding registers and memory
module pdu_far_model (
  // Clock, reset and bench controls
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_slow,
  input  wire logic [31:0]           i_bad_addr,
  input  wire logic [7:0]            i_want,
  // Peripheral side
  output logic [7:0]                 o_req,
  input  wire logic                  i_per_valid,
  output logic                       o_per_ready,
  output logic [31:0]                o_per_rdata,
  // Memory side
  input  wire logic                  i_mem_valid,
  input  wire pdu_pkg::pdu_mem_req_t i_mem_req,
  output logic                       o_mem_ready,
  output logic                       o_mem_err,
  output logic [31:0]                o_mem_rdata
);
  logic [1:0]  wait_reg;
  logic [31:0] tick_reg;
  // Stall counter, so a slow answer comes on the third cycle of a request
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wait_reg <= 2'h0;
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_reg + 32'h1;
      wait_reg <= ((i_per_valid && !o_per_ready) || (i_mem_valid && !o_mem_ready)) ?
                  wait_reg + 2'h1 : 2'h0;
    end
  end
  // A peripheral asks for service while the bench holds its want bit
  assign o_req       = i_want;
  assign o_per_ready = i_per_valid && (!i_slow || wait_reg == 2'h2);
  assign o_mem_ready = i_mem_valid && (!i_slow || wait_reg == 2'h2);
  assign o_mem_err   = o_mem_ready && (i_mem_req.addr == i_bad_addr);
  // Data outside the answer cycle moves every clock, so stale data never matches
  assign o_per_rdata = o_per_ready ? 32'hc3a5_5a3c : ~tick_reg;
  assign o_mem_rdata = o_mem_ready ? 32'h8e71_d24b : tick_reg;
endmodule

// [dv/pdu_dma_tb.sv]
// Self-checking bench for the peripheral DMA unit
`include "pdu_defs.svh"
module pdu_dma_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0, i_srst = 1'b1, run = 1'b1, slow = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, bad = 32'h0bad_0000, rd_q, rdata, per_rdata, mem_rdata;
  logic [3:0]  ev = 4'h0, irq;
  logic [7:0]  want = 8'h0, req, ack;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        per_valid, per_ready, mem_valid, mem_ready, mem_err;
  logic [1:0]  bresp, rresp, rs_q, bs_q;
  pdu_pkg::pdu_per_req_t per_req;
  pdu_pkg::pdu_mem_req_t mem_req;
  logic [31:0] mem_a[$], mem_d[$], per_a[$], per_d[$];
  logic [7:0]  ack_q[$];
  logic [2:0]  mem_s[$];
  int          err_count = 0;
  int          compares = 0;

  // Free-running clock, 8 ns period
  always #4 i_clk = ~i_clk;

  pdu_dma DUT (.i_clk(i_clk), .i_srst(i_srst), .i_clk_run(run),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_per_req(req), .o_per_ack(ack), .i_event(ev), .o_per_valid(per_valid),
    .o_per_req(per_req), .i_per_ready(per_ready), .i_per_rdata(per_rdata),
    .o_mem_valid(mem_valid), .o_mem_req(mem_req), .i_mem_ready(mem_ready),
    .i_mem_err(mem_err), .i_mem_rdata(mem_rdata), .o_irq(irq));

  pdu_far_model far (.i_clk(i_clk), .i_srst(i_srst), .i_slow(slow), .i_bad_addr(bad),
    .i_want(want), .o_req(req), .i_per_valid(per_valid), .o_per_ready(per_ready),
    .o_per_rdata(per_rdata), .i_mem_valid(mem_valid), .i_mem_req(mem_req),
    .o_mem_ready(mem_ready), .o_mem_err(mem_err), .o_mem_rdata(mem_rdata));

  // Log every completed access and every grant; frozen cycles move nothing
  always @(posedge i_clk) if (run) begin
    if (mem_valid && mem_ready) begin
      mem_a.push_back(mem_req.addr);
      mem_d.push_back(mem_req.wdata);
      mem_s.push_back({mem_req.write, mem_req.size});
    end
    if (per_valid && per_ready) begin
      per_a.push_back(per_req.addr);
      per_d.push_back(per_req.wdata);
    end
    if (ack != 8'h0) ack_q.push_back(ack);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, m, got, exp);
    end
  endtask

  // Write: address and data offered together, bready held until bvalid
  task automatic wr(input int ch, input logic [5:0] off, input logic [31:0] d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= 12'(ch * 64) + 12'(off);
    wdata <= d;
    do @(posedge i_clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge i_clk); while (!bvalid);
    bs_q = bresp;
    bready <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input int ch, input logic [5:0] off);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= 12'(ch * 64) + 12'(off);
    do @(posedge i_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge i_clk); while (!rvalid);
    rd_q = rdata;
    rs_q = rresp;
    rready <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rc(input int ch, input logic [5:0] off, input logic [31:0] e, input string m);
    rd(ch, off);
    chk(rd_q, e, m);
  endtask

  // Bounded wait on the access log rather than a fixed cycle count
  task automatic wait_mem(input int n);
    int k;
    k = 0;
    while (mem_a.size() < n && k < 500) begin
      @(posedge i_clk);
      k++;
    end
    chk(32'(mem_a.size() >= n), 32'h1, "access count");
  endtask

  task automatic clr;
    mem_a.delete();
    mem_d.delete();
    mem_s.delete();
    per_a.delete();
    per_d.delete();
    ack_q.delete();
  endtask

  task automatic t_reset;
    rc(0, `PDU_OFF_ADDR_NOW, 32'h0, "address reset");
    rc(3, `PDU_OFF_ITEMS_NEXT, 32'h0, "reload count reset");
    rc(0, `PDU_OFF_IRQ_FLAG, 32'h3, "idle flags");
    rc(0, `PDU_OFF_IRQ_MASK, 32'h0, "mask reset");
    rc(0, 6'h30, 32'h0, "unmapped data");
    chk({30'h0, rs_q}, {30'h0, `PDU_RESP_SLVERR}, "unmapped resp");
    wr(0, 6'h30, 32'h0);
    chk({30'h0, bs_q}, {30'h0, `PDU_RESP_SLVERR}, "unmapped write resp");
  endtask

  // Byte items, peripheral to memory, slow partner, then one reload
  task automatic t_byte;
    clr;
    slow <= 1'b1;
    wr(0, `PDU_OFF_SRC_SEL, 32'h01);
    wr(0, `PDU_OFF_CONFIG, {30'h0, `PDU_W_BYTE});
    wr(0, `PDU_OFF_ADDR_NOW, 32'h101);
    wr(0, `PDU_OFF_COMMAND, 32'h1);
    rc(0, `PDU_OFF_STATE, 32'h1, "enabled");
    wr(0, `PDU_OFF_ITEMS_LEFT, 32'h3);
    wr(0, `PDU_OFF_ADDR_NEXT, 32'h180);
    wr(0, `PDU_OFF_ITEMS_NEXT, 32'h1);
    want <= 8'h02;
    wait_mem(4);
    want <= 8'h0;
    for (int i = 0; i < 4; i++) begin
      chk(mem_a[i], (i < 3) ? 32'h101 + i : 32'h180, "byte address");
      chk(mem_d[i], 32'h3c3c_3c3c, "byte data");
      chk({29'h0, mem_s[i]}, {29'h0, 1'b1, `PDU_W_BYTE}, "byte size");
      chk(per_a[i], `PDU_PER_BASE + 32'h4, "holding register");
    end
    chk(32'(ack_q.size()), 32'h4, "ack count");
    rc(0, `PDU_OFF_ADDR_NOW, 32'h181, "address after reload");
    rc(0, `PDU_OFF_ITEMS_NEXT, 32'h0, "reload cleared");
    rc(0, `PDU_OFF_ITEMS_LEFT, 32'h0, "count done");
  endtask

  // Word items, memory to peripheral, circular, loaded through the reload count
  task automatic t_ring;
    clr;
    slow <= 1'b0;
    wr(1, `PDU_OFF_SRC_SEL, 32'h82);
    wr(1, `PDU_OFF_CONFIG, {29'h0, 1'b1, `PDU_W_WORD});
    wr(1, `PDU_OFF_ADDR_NEXT, 32'h200);
    wr(1, `PDU_OFF_ITEMS_NEXT, 32'h2);
    rc(1, `PDU_OFF_ITEMS_LEFT, 32'h2, "direct load count");
    rc(1, `PDU_OFF_ADDR_NOW, 32'h200, "direct load address");
    rc(1, `PDU_OFF_ITEMS_NEXT, 32'h2, "ring keeps reload");
    wr(1, `PDU_OFF_COMMAND, 32'h1);
    want <= 8'h04;
    wait_mem(5);
    want <= 8'h0;
    wr(1, `PDU_OFF_COMMAND, 32'h2);
    rc(1, `PDU_OFF_STATE, 32'h0, "disabled");
    for (int i = 0; i < 5; i++) begin
      chk(mem_a[i], 32'h200 + 4 * (i % 2), "ring address");
      chk(per_d[i], 32'h8e71_d24b, "word to peripheral");
    end
    chk(per_a[0], `PDU_PER_BASE + 32'h8, "write register");
  endtask

  // Two halfword channels, opposite directions, asking in the same cycle
  task automatic t_prio;
    clr;
    for (int c = 2; c < 4; c++) begin
      wr(c, `PDU_OFF_SRC_SEL, (c == 2) ? 32'h84 : 32'h05);
      wr(c, `PDU_OFF_CONFIG, {30'h0, `PDU_W_HALF});
      wr(c, `PDU_OFF_ITEMS_LEFT, 32'h1);
      wr(c, `PDU_OFF_COMMAND, 32'h1);
    end
    want <= 8'h30;
    wait_mem(2);
    want <= 8'h0;
    chk({24'h0, ack_q[0]}, 32'h10, "lowest first");
    chk({24'h0, ack_q[1]}, 32'h20, "other served");
    chk(per_d[0], 32'h0000_d24b, "half to peripheral");
    chk(mem_d[1], 32'h5a3c_5a3c, "half to memory");
    chk({29'h0, mem_s[0]}, {29'h0, 1'b0, `PDU_W_HALF}, "read from memory");
    chk({29'h0, mem_s[1]}, {29'h0, 1'b1, `PDU_W_HALF}, "write to memory");
    rc(2, `PDU_OFF_ADDR_NOW, 32'h2, "half step");
  endtask

  // Memory fault on the first item of the block, release, then mask handling
  task automatic t_fault;
    clr;
    wr(0, `PDU_OFF_SRC_SEL, 32'h06);
    wr(0, `PDU_OFF_ADDR_NOW, bad);
    wr(0, `PDU_OFF_IRQ_EN, 32'h4);
    wr(0, `PDU_OFF_ITEMS_LEFT, 32'h2);
    want <= 8'h40;
    wait_mem(1);
    repeat (4) @(posedge i_clk);
    rc(0, `PDU_OFF_STATE, 32'h3, "faulted");
    rc(0, `PDU_OFF_IRQ_FLAG, 32'h5, "fault flag");
    chk({31'h0, irq[0]}, 32'h1, "irq raised");
    rc(0, `PDU_OFF_ITEMS_LEFT, 32'h2, "no count on fault");
    wr(0, `PDU_OFF_ADDR_NOW, 32'h400);
    wr(0, `PDU_OFF_COMMAND, 32'h100);
    wait_mem(3);
    want <= 8'h0;
    chk(mem_a[2], 32'h401, "restart address");
    rc(0, `PDU_OFF_IRQ_FLAG, 32'h3, "finished");
    rc(0, `PDU_OFF_IRQ_MASK, 32'h4, "mask set");
    wr(0, `PDU_OFF_IRQ_DIS, 32'h4);
    rc(0, `PDU_OFF_IRQ_MASK, 32'h0, "mask cleared");
  endtask

  // Event gating, with the clock stopped between event and transfer
  task automatic t_event;
    clr;
    wr(3, `PDU_OFF_CONFIG, 32'h8);
    wr(3, `PDU_OFF_ITEMS_LEFT, 32'h2);
    want <= 8'h20;
    repeat (10) @(posedge i_clk);
    chk(32'(mem_a.size()), 32'h0, "held for event");
    ev <= 4'h8;
    @(posedge i_clk);
    ev <= 4'h0;
    run <= 1'b0;
    repeat (20) @(posedge i_clk);
    chk(32'(mem_a.size()), 32'h0, "frozen");
    run <= 1'b1;
    repeat (20) @(posedge i_clk);
    chk(32'(mem_a.size()), 32'h1, "one per event");
    want <= 8'h0;
    rc(3, `PDU_OFF_ITEMS_LEFT, 32'h1, "count resumed");
  endtask

  task automatic summarize;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    t_reset;
    t_byte;
    t_ring;
    t_prio;
    t_fault;
    t_event;
    summarize;
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    summarize;
  end
endmodule
